/* tiop_pkg.sv */
// Shared constants for the timed I/O port block and its clock blocks.
package tiop_pkg;
  localparam int unsigned NPORT     = 5;
  localparam int unsigned PIN_W     = 32;
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned DIV_W     = 8;
  localparam int unsigned CLKSEL_W  = 3;
  localparam int unsigned PORT_WIDTH [NPORT] = '{1, 4, 8, 16, 32};
  localparam int unsigned REF_MHZ   = 100;
  localparam logic [PIN_W-1:0] LINK_PIN_MASK = 32'hFF00_0000;
  localparam logic [3:0] UNIT_CLK_BASE = 4'h8;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_DATA   = 4'h1;
  localparam logic [3:0] REG_COND   = 4'h2;
  localparam logic [3:0] REG_TIME   = 4'h3;
  localparam logic [3:0] REG_COUNT  = 4'h4;
  localparam logic [3:0] REG_STAMP  = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] CB_CTRL    = 4'h0;
  localparam logic [3:0] CB_DIV     = 4'h1;
  localparam int unsigned CTRL_EN       = 0;
  localparam int unsigned CTRL_OUT      = 1;
  localparam int unsigned CTRL_OD       = 2;
  localparam int unsigned CTRL_COND_LSB = 3;
  localparam int unsigned CTRL_SIN      = 5;
  localparam int unsigned CTRL_SOUT     = 6;
  localparam int unsigned CTRL_CLK_LSB  = 8;
  localparam int unsigned CTRL_W        = 11;
  localparam int unsigned CB_SRC_PIN    = 0;
  localparam int unsigned STAT_FULL     = 0;
  localparam int unsigned STAT_PEND     = 1;
  localparam int unsigned STAT_TARM     = 2;
  localparam logic [1:0] COND_NONE = 2'h0;
  localparam logic [1:0] COND_EQ   = 2'h1;
  localparam logic [1:0] COND_NEQ  = 2'h2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
  localparam logic [DIV_W-1:0]  DIV_RESET  = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
endpackage : tiop_pkg

/* tiop_clkblk.sv */
// Programmable clock block that turns the reference or a pin edge into a divided tick.
`timescale 1ns/1ps
module tiop_clkblk
  import tiop_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             src_pin,
  input  wire logic             src_sel,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick
);
  logic             pin_prev_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic             src_edge;

  assign src_edge = src_sel ? (src_pin & ~pin_prev_reg) : 1'b1;
  assign tick     = src_edge && (div_cnt_reg == div);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      pin_prev_reg <= 1'b0;
    else
      pin_prev_reg <= src_pin;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      div_cnt_reg <= DIV_RESET;
    else if (src_edge)
      div_cnt_reg <= (div_cnt_reg >= div) ? DIV_RESET : div_cnt_reg + 1'b1;
  end

  a_div_spacing : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && div != DIV_RESET && $stable(div)) |=> !tick)
    else $error("Divided clock block ticked twice in a row.");
endmodule : tiop_clkblk

/* tiop_pinmux.sv */
// Pin sharing: narrowest enabled port owns a pin, and an enabled link takes pins away.
`timescale 1ns/1ps
module tiop_pinmux
  import tiop_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic [NPORT-1:0]       port_en,
  input  wire logic [NPORT-1:0]       port_out,
  input  wire logic [NPORT-1:0]       port_od,
  input  wire logic [NPORT*PIN_W-1:0] port_drv,
  input  wire logic                   link_en,
  output logic      [PIN_W-1:0]       pin_out,
  output logic      [PIN_W-1:0]       pin_oe
);
  genvar i;
  generate
    for (i = 0; i < PIN_W; i++)
    begin : g_pin
      always_comb
      begin
        logic found;
        logic dbit;
        logic is_out;
        logic is_od;
        found  = 1'b0;
        dbit   = 1'b0;
        is_out = 1'b0;
        is_od  = 1'b0;
        // Wider ports are visited first so that a narrower enabled port overrides them.
        for (int p = NPORT - 1; p >= 0; p--)
        begin
          if (port_en[p] && (i < PORT_WIDTH[p]))
          begin
            found  = 1'b1;
            dbit   = port_drv[p*PIN_W + i];
            is_out = port_out[p];
            is_od  = port_od[p];
          end
        end
        if (link_en && LINK_PIN_MASK[i])
          found = 1'b0;
        pin_out[i] = found & is_out & dbit & ~is_od;
        pin_oe[i]  = found & is_out & ~(is_od & dbit);
      end
    end
  endgenerate

  a_link_release : assert property (@(posedge ref_clk) disable iff (!rst_b)
    link_en |-> ((pin_oe & LINK_PIN_MASK) == '0))
    else $error("Pin driven while the link owns it.");

  a_narrow_wins : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (port_en[0] && port_out[0] && !port_od[0] && !(link_en && LINK_PIN_MASK[0]))
      |-> (pin_out[0] == port_drv[0] && pin_oe[0]))
    else $error("Single-bit port did not own its pin.");

  a_od_release : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pin_oe != '0) |-> ((pin_out & ~pin_oe) == '0))
    else $error("Open-collector pin released but shows a high drive.");
endmodule : tiop_pinmux

/* tiop_top.sv */
// Timed I/O ports with port counters, timestamps, strobes and six clock blocks.
//
// Contract
// - Ports of width 1, 4, 8, 16 and 32 bits, all starting at pin 0 and sharing pins.
// - All pins of one port are inputs or all are outputs.
// - Ports drive pins or sample them, optionally waiting for a pin condition.
// - Open-collector option per port: drive low for zero, release for one.
// - Data moves through a pin-side shift stage and a transfer register; input captures load the transfer register from the pins.
// - Each port has a 16-bit counter timing transfers.
// - Counter readable any time; transfers can wait for a future count.
// - Every transfer captures the counter as a readable timestamp.
// - An enabled link disables the ports on its pins; here it only releases their drive, and input ports still sample those pins.
// - An enabled narrower port overrides wider ports on shared pins.
// - Unshared pins of a wider port stay usable.
// - A port always transfers its full nominal width.
// - Six clock blocks; block 0 is the reference, others programmable.
// - A clock block may take a single-bit port pin as its source.
// - A pin-sourced clock block may divide its input.
// - Ports accept an incoming strobe and can generate an outgoing strobe.
// - At reset every port is attached to clock block 0.
// - A processor access completes in a single cycle.
// - Pin conditions become events sent to the scheduler.
// - During reset every pin has its pull-down enabled.
`timescale 1ns/1ps
module tiop_top
  import tiop_pkg::*;
#(
  parameter int unsigned NCB = 6
)
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  input  wire logic [7:0]              addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic      [31:0]             rdata,
  input  wire logic [tiop_pkg::PIN_W-1:0] pin_in,
  output logic      [tiop_pkg::PIN_W-1:0] pin_out,
  output logic      [tiop_pkg::PIN_W-1:0] pin_oe,
  output logic                         pin_pd_en,
  input  wire logic                    link_en,
  input  wire logic [tiop_pkg::NPORT-1:0] strobe_in,
  output logic      [tiop_pkg::NPORT-1:0] strobe_out,
  output logic      [tiop_pkg::NPORT-1:0] port_event
);
  import tiop_pkg::*;

  generate
    if (NCB < 2 || NCB > (1 << CLKSEL_W))
    begin : g_bad_ncb
      $error("NCB must lie between 2 and the clock select range.");
    end
  endgenerate

  logic [NCB-1:0]          cb_tick;
  logic [NCB-1:0]          cb_src_reg;
  logic [DIV_W-1:0]        cb_div_reg [NCB];
  logic [CTRL_W-1:0]       ctrl_reg   [NPORT];
  logic [PIN_W-1:0]        cond_reg   [NPORT];
  logic [CNT_W-1:0]        time_reg   [NPORT];
  logic [CNT_W-1:0]        cnt_reg    [NPORT];
  logic [CNT_W-1:0]        stamp_reg  [NPORT];
  logic [PIN_W-1:0]        xfer_reg   [NPORT];
  logic [PIN_W-1:0]        shift_reg  [NPORT];
  logic [NPORT-1:0]        full_reg;
  logic [NPORT-1:0]        pend_reg;
  logic [NPORT-1:0]        tarm_reg;
  logic [NPORT-1:0]        sout_reg;
  logic [NPORT-1:0]        evt_reg;
  logic [NPORT-1:0]        port_tick;
  logic [NPORT-1:0]        cap;
  logic [NPORT-1:0]        drive;
  logic [NPORT-1:0]        p_en;
  logic [NPORT-1:0]        p_out;
  logic [NPORT-1:0]        p_od;
  logic [NPORT*PIN_W-1:0]  drv_flat;
  logic [31:0]             rdata_reg;
  logic [31:0]             rdata_next;
  logic [3:0]              unit;
  logic [3:0]              sel;

  assign unit       = addr[7:4];
  assign sel        = addr[3:0];
  assign rdata      = rdata_reg;
  assign strobe_out = sout_reg;
  assign port_event = evt_reg;
  assign pin_pd_en  = ~rst_b;

  // Clock block 0 is the reference and ticks every cycle; the rest are programmable.
  assign cb_tick[0] = 1'b1;

  genvar k;
  generate
    for (k = 1; k < NCB; k++)
    begin : g_cb
      tiop_clkblk u_cb (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .src_pin (pin_in[0]),
        .src_sel (cb_src_reg[k]),
        .div     (cb_div_reg[k]),
        .tick    (cb_tick[k])
      );
    end
  endgenerate

  generate
    for (k = 0; k < NCB; k++)
    begin : g_cb_regs
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
        begin
          cb_src_reg[k] <= 1'b0;
          cb_div_reg[k] <= DIV_RESET;
        end
        else if (wr_en && unit == UNIT_CLK_BASE + 4'(k) && k != 0)
        begin
          if (sel == CB_CTRL)
            cb_src_reg[k] <= wdata[CB_SRC_PIN];
          else if (sel == CB_DIV)
            cb_div_reg[k] <= wdata[DIV_W-1:0];
        end
      end
    end
  endgenerate

  genvar p;
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_port
      localparam logic [PIN_W-1:0] MASK = PIN_W'((64'h1 << PORT_WIDTH[p]) - 64'h1);
      logic [CLKSEL_W-1:0] clk_sel;
      logic [1:0]          cmode;
      logic [PIN_W-1:0]    pins;
      logic                cond_ok;
      logic                time_ok;
      logic                strobe_ok;
      logic                wr_hit;
      logic                rd_data_hit;

      assign clk_sel     = ctrl_reg[p][CTRL_CLK_LSB +: CLKSEL_W];
      assign cmode       = ctrl_reg[p][CTRL_COND_LSB +: 2];
      assign port_tick[p] = (clk_sel < NCB) ? cb_tick[clk_sel] : cb_tick[0];
      assign pins        = pin_in & MASK;
      assign wr_hit      = wr_en && unit == 4'(p);
      assign rd_data_hit = rd_en && unit == 4'(p) && sel == REG_DATA;
      assign p_en[p]     = ctrl_reg[p][CTRL_EN];
      assign p_out[p]    = ctrl_reg[p][CTRL_OUT];
      assign p_od[p]     = ctrl_reg[p][CTRL_OD];
      assign drv_flat[p*PIN_W +: PIN_W] = shift_reg[p];

      always_comb
      begin
        if (cmode == COND_EQ)
          cond_ok = (pins == cond_reg[p]);
        else if (cmode == COND_NEQ)
          cond_ok = (pins != cond_reg[p]);
        else
          cond_ok = 1'b1;
      end

      assign time_ok   = !tarm_reg[p] || (cnt_reg[p] == time_reg[p]);
      assign strobe_ok = !ctrl_reg[p][CTRL_SIN] || strobe_in[p];
      assign cap[p]    = p_en[p] && !p_out[p] && port_tick[p] && !full_reg[p]
                         && cond_ok && time_ok && strobe_ok;
      assign drive[p]  = p_en[p] && p_out[p] && port_tick[p] && pend_reg[p] && time_ok;

      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          ctrl_reg[p] <= CTRL_RESET;
        else if (wr_hit && sel == REG_CTRL)
          ctrl_reg[p] <= wdata[CTRL_W-1:0];
      end

      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
        begin
          cond_reg[p] <= '0;
          time_reg[p] <= CNT_RESET;
        end
        else if (wr_hit && sel == REG_COND)
          cond_reg[p] <= wdata & MASK;
        else if (wr_hit && sel == REG_TIME)
          time_reg[p] <= wdata[CNT_W-1:0];
      end

      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          cnt_reg[p] <= CNT_RESET;
        else if (port_tick[p])
          cnt_reg[p] <= cnt_reg[p] + 1'b1;
      end

      // A write to the time register arms the wait; the transfer it gates disarms it.
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          tarm_reg[p] <= 1'b0;
        else if (wr_hit && sel == REG_TIME)
          tarm_reg[p] <= 1'b1;
        else if (cap[p] || drive[p])
          tarm_reg[p] <= 1'b0;
      end

      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          xfer_reg[p] <= '0;
        else if (wr_hit && sel == REG_DATA && p_out[p])
          xfer_reg[p] <= wdata & MASK;
        else if (cap[p])
          xfer_reg[p] <= pins;
      end

      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          shift_reg[p] <= '0;
        else if (drive[p])
          shift_reg[p] <= xfer_reg[p];
      end

      // Capture wins over a read in the same cycle so no sample is lost.
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          full_reg[p] <= 1'b0;
        else if (cap[p])
          full_reg[p] <= 1'b1;
        else if (rd_data_hit)
          full_reg[p] <= 1'b0;
      end

      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          pend_reg[p] <= 1'b0;
        else if (wr_hit && sel == REG_DATA && p_out[p])
          pend_reg[p] <= 1'b1;
        else if (drive[p])
          pend_reg[p] <= 1'b0;
      end

      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          stamp_reg[p] <= CNT_RESET;
        else if (cap[p] || drive[p])
          stamp_reg[p] <= cnt_reg[p];
      end

      // The outgoing strobe stands for one port clock period beside the new data.
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          sout_reg[p] <= 1'b0;
        else if (port_tick[p])
          sout_reg[p] <= drive[p] && ctrl_reg[p][CTRL_SOUT];
      end

      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          evt_reg[p] <= 1'b0;
        else
          evt_reg[p] <= cap[p] || drive[p];
      end

      sequence s_capture;
        cap[p] ##1 (full_reg[p] && stamp_reg[p] == $past(cnt_reg[p]));
      endsequence

      sequence s_drive;
        drive[p] ##1 (shift_reg[p] == $past(xfer_reg[p]) && (!pend_reg[p] || $past(wr_hit && sel == REG_DATA)));
      endsequence

      a_capture_stamp : assert property (@(posedge ref_clk) disable iff (!rst_b)
        cap[p] |-> s_capture)
        else $error("Capture did not store data state and timestamp.");

      a_drive_update : assert property (@(posedge ref_clk) disable iff (!rst_b)
        drive[p] |-> s_drive)
        else $error("Drive did not move transfer register to pins.");

      a_count_advance : assert property (@(posedge ref_clk) disable iff (!rst_b)
        port_tick[p] |=> cnt_reg[p] == $past(cnt_reg[p]) + 16'h0001)
        else $error("Port counter did not advance on its tick.");

      a_strobe_gate : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ctrl_reg[p][CTRL_SIN] && !strobe_in[p] && !full_reg[p]) |=> !full_reg[p])
        else $error("Input captured while the strobe was low.");

      a_time_wait : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (tarm_reg[p] && cnt_reg[p] != time_reg[p]) |-> !(cap[p] || drive[p]))
        else $error("Transfer happened before the armed count.");

      a_event_pulse : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cap[p] || drive[p]) |=> port_event[p])
        else $error("Transfer raised no event.");

      a_reset_attach : assert property (@(posedge ref_clk)
        $rose(rst_b) |-> ctrl_reg[p][CTRL_CLK_LSB +: CLKSEL_W] == '0)
        else $error("Port not on clock block 0 after reset.");
    end
  endgenerate

  tiop_pinmux u_pinmux (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .port_en  (p_en),
    .port_out (p_out),
    .port_od  (p_od),
    .port_drv (drv_flat),
    .link_en  (link_en),
    .pin_out  (pin_out),
    .pin_oe   (pin_oe)
  );

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (unit >= UNIT_CLK_BASE && 5'(unit) < 5'(UNIT_CLK_BASE) + 5'(NCB))
    begin
      if (sel == CB_CTRL)
        rdata_next = {31'h0000_0000, cb_src_reg[3'(unit - UNIT_CLK_BASE)]};
      else if (sel == CB_DIV)
        rdata_next = {24'h00_0000, cb_div_reg[3'(unit - UNIT_CLK_BASE)]};
    end
    else if (unit < 4'(NPORT))
    begin
      if (sel == REG_CTRL)
        rdata_next = {21'h00_0000, ctrl_reg[3'(unit)]};
      else if (sel == REG_DATA)
        rdata_next = xfer_reg[3'(unit)];
      else if (sel == REG_COND)
        rdata_next = cond_reg[3'(unit)];
      else if (sel == REG_TIME)
        rdata_next = {16'h0000, time_reg[3'(unit)]};
      else if (sel == REG_COUNT)
        rdata_next = {16'h0000, cnt_reg[3'(unit)]};
      else if (sel == REG_STAMP)
        rdata_next = {16'h0000, stamp_reg[3'(unit)]};
      else if (sel == REG_STATUS)
        rdata_next = {29'h0000_0000, tarm_reg[3'(unit)], pend_reg[3'(unit)], full_reg[3'(unit)]};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rdata_reg <= 32'h0000_0000;
    else if (rd_en)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 32'h0000_0000;
  end

  a_read_latency : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rd_en && unit == 4'h0 && sel == REG_COUNT) |=> rdata == {16'h0000, $past(cnt_reg[0])})
    else $error("Counter read not answered in the next cycle.");
endmodule : tiop_top

/* tiop_pin_model.sv */
// External hardware model: drives pins and strobes, makes a pin clock and resolves the pin wires.
`timescale 1ns/1ps
module tiop_pin_model
  import tiop_pkg::*;
(
  input  wire logic [tiop_pkg::PIN_W-1:0] pin_out,
  input  wire logic [tiop_pkg::PIN_W-1:0] pin_oe,
  input  wire logic                       ref_clk,
  input  wire logic                       pin_pd_en,
  input  wire logic [tiop_pkg::PIN_W-1:0] ext_val,
  input  wire logic [tiop_pkg::PIN_W-1:0] ext_oe,
  input  wire logic                       clk_run,
  input  wire logic [tiop_pkg::NPORT-1:0] stb_req,
  output logic      [tiop_pkg::PIN_W-1:0] pin_in,
  output logic      [tiop_pkg::NPORT-1:0] strobe_in
);
  logic [1:0]       ph_reg;
  logic [PIN_W-1:0] last_reg;

  // The pin clock on pin 0 has a period of four reference cycles; when stopped its phase clears to zero and pin 0 is released.
  always_ff @(posedge ref_clk)
  begin
    ph_reg   <= clk_run ? ph_reg + 2'd1 : 2'd0;
    last_reg <= pin_in;
  end

  // A pin nobody drives floats, so it shows the inverse of its last level unless pulled down.
  always_comb
  begin
    for (int i = 0; i < PIN_W; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (i == 0 && clk_run)
        pin_in[i] = ph_reg[1];
      else if (ext_oe[i])
        pin_in[i] = ext_val[i];
      else if (pin_pd_en)
        pin_in[i] = 1'b0;
      else
        pin_in[i] = ~last_reg[i];
    end
  end

  assign strobe_in = stb_req;
endmodule : tiop_pin_model

/* tiop_top_bench.sv */
// Self-checking testbench for the timed I/O port block.
`timescale 1ns/1ps
module tiop_top_bench;
  import tiop_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] exp;} tiop_row_t;
  localparam tiop_row_t ROWS [9] = '{
    '{8'h00, 32'h0000_0105, 32'h0000_0105}, '{8'h0F, 32'h1234_5678, 32'h0000_0000},
    '{8'h80, 32'h0000_0001, 32'h0000_0000}, '{8'h91, 32'h0000_00AB, 32'h0000_00AB},
    '{8'hD1, 32'h0000_0033, 32'h0000_0033}, '{8'hF0, 32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h42, 32'hDEAD_BEEF, 32'hDEAD_BEEF}, '{8'h12, 32'h0000_0005, 32'h0000_0005},
    '{8'h00, 32'h0000_0000, 32'h0000_0000}};
  logic             ref_clk = 1'b0;
  logic             rst_b   = 1'b0;
  logic [7:0]       addr    = 8'h00;
  logic [31:0]      wdata   = 32'h0000_0000;
  logic             wr_en   = 1'b0;
  logic             rd_en   = 1'b0;
  logic             link_en = 1'b0;
  logic             clk_run = 1'b0;
  logic [PIN_W-1:0] ext_val = 32'h0000_0000;
  logic [PIN_W-1:0] ext_oe  = 32'h0000_0000;
  logic [NPORT-1:0] stb_req = 5'h00;
  logic [31:0]      rdata;
  logic [31:0]      c0;
  logic [31:0]      c1;
  logic [PIN_W-1:0] pin_in;
  logic [PIN_W-1:0] pin_out;
  logic [PIN_W-1:0] pin_oe;
  logic             pin_pd_en;
  logic [NPORT-1:0] strobe_in;
  logic [NPORT-1:0] strobe_out;
  logic [NPORT-1:0] port_event;
  int               failures    = 0;
  int               check_count = 0;
  int               n;

  always #12.5 ref_clk = ~ref_clk;

  tiop_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pd_en(pin_pd_en),
    .link_en(link_en), .strobe_in(strobe_in), .strobe_out(strobe_out), .port_event(port_event));
  tiop_pin_model ext (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pd_en(pin_pd_en),
    .ext_val(ext_val), .ext_oe(ext_oe), .clk_run(clk_run), .stb_req(stb_req), .pin_in(pin_in),
    .strobe_in(strobe_in));

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdchk

  // Waits for a transfer pulse of one port; a missing pulse ends the run.
  task automatic wait_evt(input int p, input int lim, output int waited);
    for (waited = 1; waited <= lim; waited++)
    begin
      @(posedge ref_clk);
      #1;
      if (port_event[p] === 1'b1)
        return;
    end
    failures++;
    $display("MISMATCH at %0t: event got %h expected %h", $time, port_event[p], 1'b1);
    finish_test();
  endtask : wait_evt

  task automatic ctrl_clear_check();
    for (int p = 0; p < NPORT; p++)
      rdchk({p[3:0], 4'h0}, 32'h0000_0000);
  endtask : ctrl_clear_check

  initial
  begin
    cyc(8);
    #1;
    chk(pin_pd_en, 1);
    chk(pin_oe, 0);
    rst_b <= 1'b1;
    cyc(1);
    #1;
    chk(pin_pd_en, 0);
    ctrl_clear_check();
    foreach (ROWS[i])
    begin
      wr(ROWS[i].a, ROWS[i].d);
      rdchk(ROWS[i].a, ROWS[i].exp);
    end
    // Output transfer on the reference clock block with an outgoing strobe.
    wr(8'h00, 32'h0000_0043);
    wr(8'h01, 32'h0000_0001);
    wait_evt(0, 8, n);
    chk({pin_out[0], pin_oe[0], strobe_out[0]}, 3'b111);
    // Deferred output: the drive waits for the counter and stamps the time it happened.
    rd(8'h04, c0);
    wr(8'h03, {16'h0000, c0[15:0] + 16'd20});
    wr(8'h01, 32'h0000_0000);
    wait_evt(0, 40, n);
    chk(n >= 10, 1);
    chk({pin_oe[0], pin_out[0]}, 2'b10);
    rdchk(8'h05, {16'h0000, c0[15:0] + 16'd20});
    // Open collector releases the pin for a one and drives it for a zero.
    wr(8'h00, 32'h0000_0007);
    wr(8'h01, 32'h0000_0001);
    wait_evt(0, 8, n);
    chk(pin_oe[0], 0);
    wr(8'h01, 32'h0000_0000);
    wait_evt(0, 8, n);
    chk({pin_oe[0], pin_out[0]}, 2'b10);
    wr(8'h00, 32'h0000_0000);
    // Strobe-gated input capture on the 4-bit port.
    ext_oe  <= 32'hFFFF_FFFF;
    ext_val <= 32'h0000_000A;
    wr(8'h10, 32'h0000_0021);
    cyc(10);
    rdchk(8'h16, 32'h0000_0000);
    stb_req <= 5'h02;
    wait_evt(1, 8, n);
    rdchk(8'h11, 32'h0000_000A);
    stb_req <= 5'h00;
    wr(8'h10, 32'h0000_0000);
    // Conditional sampling, equal and not-equal, on the 8-bit port.
    wr(8'h22, 32'h0000_005A);
    for (int m = 1; m <= 2; m++)
    begin
      wr(8'h20, 32'h0000_0000);
      rd(8'h21, c1);
      ext_val <= (m == 1) ? 32'h0000_0000 : 32'h0000_005A;
      wr(8'h20, 32'h0000_0001 | (m << CTRL_COND_LSB));
      cyc(10);
      rdchk(8'h26, 32'h0000_0000);
      ext_val <= (m == 1) ? 32'h0000_005A : 32'h0000_003C;
      wait_evt(2, 8, n);
      rdchk(8'h21, (m == 1) ? 32'h0000_005A : 32'h0000_003C);
    end
    wr(8'h20, 32'h0000_0000);
    // Pin sharing between the 4, 16 and 32-bit output ports and the link.
    wr(8'h10, 32'h0000_0003);
    wr(8'h30, 32'h0000_0003);
    wr(8'h40, 32'h0000_0003);
    wr(8'h11, 32'h0000_0000);
    wr(8'h31, 32'h0000_FFFF);
    wr(8'h41, 32'hFFFF_FFFF);
    link_en <= 1'b1;
    cyc(3);
    #1;
    chk(pin_oe, 32'h00FF_FFFF);
    chk(pin_out & 32'h00FF_FFFF, 32'h00FF_FFF0);
    link_en <= 1'b0;
    #1;
    chk(pin_oe, 32'hFFFF_FFFF);
    for (int p = 0; p < NPORT; p++)
      wr({p[3:0], 4'h0}, 32'h0000_0000);
    // Port counter paced by a clock block fed from pin 0, with and without division.
    ext_oe  <= 32'h0000_0000;
    clk_run <= 1'b1;
    wr(8'h90, 32'h0000_0001);
    for (int d = 0; d <= 1; d++)
    begin
      wr(8'h91, d);
      wr(8'h20, 32'h0000_0101);
      cyc(16);
      rd(8'h24, c0);
      cyc(63);
      rd(8'h24, c1);
      chk({16'h0000, c1[15:0] - c0[15:0]}, 64 / (4 * (d + 1)));
    end
    clk_run <= 1'b0;
    // Reset in mid-run returns every port to its idle state.
    rst_b <= 1'b0;
    cyc(2);
    #1;
    chk(pin_pd_en, 1);
    chk(pin_oe, 0);
    rst_b <= 1'b1;
    cyc(1);
    ctrl_clear_check();
    finish_test();
  end
endmodule : tiop_top_bench
